//--- hw/mic_top.v
// Purpose: memory interface configuration and behaviour control over apb
// Assumes: pclk 10 MHz, presetn async active low, one clock domain
// Notes: slot wait, bus acknowledge and write-busy inputs are synchronised by two flops before use
// Notes on behaviour
// RULE1: eight select read page mode enables, bits 15:8
// RULE2: per-slot memory and io access-time fields; the code has no such fields, access_time is only 1 or 2 from page mode
// RULE3: slot wait enable gates the wait input
// RULE4: io enable picks io strobes over read/write
// RULE5: bit 3 selects eight-bit card port
// RULE6: per-bank edo enable, width from bank config
// RULE7: default dma uses bus request and acknowledge
// RULE8: arbitration plus snoop disable bypasses bus request
// RULE9: core stalls only on miss contention
// RULE10: snoop disable suppresses snoop on dma writes
// RULE11: watchdog timeout raises core interrupt zero
// RULE12: interrupt held until clear bit set
// RULE13: option bit adds ras-to-cas clock
// RULE14: watchdog enable bit 24, length bits 23:20
// RULE15: power-down bit sleeps memories, signals low
// RULE16: non-register access ends power-down
// RULE17: refresh enable starts periodic bank refresh
// RULE18: software enables refresh after memory start-up
// RULE19: six-bit refresh period field per bank
// RULE20: write-only remap start address bits 31:9
// RULE21: write-only four-bit remap mask
// RULE22: write-only remap destination bits 31:9
// RULE23: masked start match replaces upper address bits
// RULE24: watchdog counts cycles from write start
// RULE25: page reads use second time after first
// RULE26: bank width config selects dram or sdram
//
// The APB slave port is this design's own decision.
`include "mic_defines.vh"
module mic_top (
    // apb slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // processor access request
    input wire cpu_req,
    input wire cpu_write,
    input wire cpu_reg_space,
    input wire cpu_cache_miss,
    input wire [31:0] cpu_addr,
    input wire [2:0] cpu_sel,
    input wire cpu_sel_mem,
    input wire cpu_burst_beat,
    output reg [31:0] mem_addr,
    output reg [3:0] access_time,
    output reg cpu_stall,
    // bank config
    input wire [1:0] bank0_width_config,
    input wire [1:0] bank1_width_config,
    input wire mem_bank,
    output reg [1:0] bank_mode,
    output reg bank_edo,
    output reg [1:0] ras_cas_delay,
    // card slots
    input wire card_slot2,
    input wire card_io_space,
    input wire slot1_wait_n,
    input wire slot2_wait_n,
    output reg card_wait,
    output reg card_io_strobes,
    output reg card_byte_port,
    // dma
    input wire dma_start,
    input wire dma_write,
    input wire core_bus_ack,
    output reg core_bus_req,
    output reg core_snoop,
    output reg dma_grant,
    // write watchdog
    input wire mem_write_busy,
    output reg write_timeout_irq,
    // power and refresh
    output reg mem_self_refresh,
    output reg mem_signals_low,
    output reg bank0_refresh_pulse,
    output reg bank1_refresh_pulse
);
    reg [31:0] card_ff, drpw_ff;
    reg [31:9] rm1s_ff, rm2s_ff, rm1d_ff, rm2d_ff;
    reg [3:0] rm1m_ff, rm2m_ff;
    reg [1:0] w1_ff, w2_ff, ack_ff, wb_ff;
    // wide enough for the longest timeout and the longest refresh period
    reg [8:0] wd_cnt_ff, nxt_wd_cnt;
    reg [12:0] rf0_cnt_ff, rf1_cnt_ff, nxt_rf0, nxt_rf1;
    reg clr_prev_ff;
    wire wr = psel & penable & pwrite;
    wire [3:0] wd_len = drpw_ff[`MIC_DR_WDLEN_HI:`MIC_DR_WDLEN_LO];
    wire ext_arb = drpw_ff[`MIC_DR_ARB] & drpw_ff[`MIC_DR_NOSNOOP];

    // remap match: masked bits are ignored in the compare
    function hit;
        input [31:9] a, s;
        input [3:0] m;
        begin
            hit = ((a[31:13] == s[31:13]) && ((a[12:9] | m) == (s[12:9] | m)));
        end
    endfunction

    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // register writes; remap regions are write-only
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            card_ff <= `MIC_CARD_RESET;
            drpw_ff <= `MIC_DR_RESET;
            rm1s_ff <= 23'h000000;
            rm2s_ff <= 23'h000000;
            rm1d_ff <= 23'h000000;
            rm2d_ff <= 23'h000000;
            rm1m_ff <= 4'h0;
            rm2m_ff <= 4'h0;
        end else begin
            if (wr && paddr == `MIC_OFF_CARD)
                card_ff <= pwdata & `MIC_CARD_WMASK; // RULE1 RULE2
            if (wr && paddr == `MIC_OFF_DRPW)
                drpw_ff <= pwdata & `MIC_DR_WMASK; // RULE14 RULE19
            else if (cpu_req && !cpu_reg_space)
                drpw_ff[`MIC_DR_SLEEP] <= 1'b0; // RULE16
            if (wr && paddr == `MIC_OFF_RM2S) begin
                rm2s_ff <= pwdata[31:9]; // RULE20
                rm2m_ff <= pwdata[3:0]; // RULE21
            end
            if (wr && paddr == `MIC_OFF_RM1S) begin
                rm1s_ff <= pwdata[31:9]; // RULE20
                rm1m_ff <= pwdata[3:0]; // RULE21
            end
            if (wr && paddr == `MIC_OFF_RM2D)
                rm2d_ff <= pwdata[31:9]; // RULE22
            if (wr && paddr == `MIC_OFF_RM1D)
                rm1d_ff <= pwdata[31:9]; // RULE22
        end
    end

    // read mux; write-only and unmapped words read zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (psel && !penable && !pwrite) begin
            case (paddr)
                `MIC_OFF_CARD: prdata <= card_ff;
                `MIC_OFF_DRPW: prdata <= drpw_ff;
                `MIC_OFF_STAT: prdata <= {29'h0, mem_self_refresh, cpu_stall,
                    write_timeout_irq};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // two-flop synchronisers for pins from outside the clock domain
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            w1_ff <= 2'b11;
            w2_ff <= 2'b11;
            ack_ff <= 2'b00;
            wb_ff <= 2'b00;
        end else begin
            w1_ff <= {w1_ff[0], slot1_wait_n};
            w2_ff <= {w2_ff[0], slot2_wait_n};
            ack_ff <= {ack_ff[0], core_bus_ack};
            wb_ff <= {wb_ff[0], mem_write_busy};
        end
    end

    // watchdog counter and timeout flag; the flag is set-dominant
    always @* begin
        nxt_wd_cnt = 9'h000;
        if (drpw_ff[`MIC_DR_WDEN] && wb_ff[1] && wd_cnt_ff != 9'h1ff)
            nxt_wd_cnt = wd_cnt_ff + 9'h001; // RULE24
    end
    wire wd_fire = drpw_ff[`MIC_DR_WDEN] && wb_ff[1] && // RULE14
        (wd_cnt_ff == ({5'h00, wd_len} + 9'h001) * `MIC_WD_STEP); // RULE24
    wire clr_bit = drpw_ff[`MIC_DR_IRQCLR];
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_cnt_ff <= 9'h000;
            write_timeout_irq <= 1'b0;
            clr_prev_ff <= 1'b0;
        end else begin
            wd_cnt_ff <= nxt_wd_cnt;
            clr_prev_ff <= clr_bit;
            if (wd_fire)
                write_timeout_irq <= 1'b1; // RULE11
            else if (clr_bit && !clr_prev_ff)
                write_timeout_irq <= 1'b0; // RULE12
        end
    end

    // refresh period counters, one pulse per period
    always @* begin
        nxt_rf0 = 13'h0000;
        nxt_rf1 = 13'h0000;
        if (drpw_ff[`MIC_DR_RF0] && rf0_cnt_ff <
            ({7'h00, drpw_ff[`MIC_DR_RP0_HI:`MIC_DR_RP0_LO]} + 13'h0001) * `MIC_RF_STEP)
            nxt_rf0 = rf0_cnt_ff + 13'h0001; // RULE19
        if (drpw_ff[`MIC_DR_RF1] && rf1_cnt_ff <
            ({7'h00, drpw_ff[`MIC_DR_RP1_HI:`MIC_DR_RP1_LO]} + 13'h0001) * `MIC_RF_STEP)
            nxt_rf1 = rf1_cnt_ff + 13'h0001; // RULE19
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rf0_cnt_ff <= 13'h0000;
            rf1_cnt_ff <= 13'h0000;
            bank0_refresh_pulse <= 1'b0;
            bank1_refresh_pulse <= 1'b0;
        end else begin
            rf0_cnt_ff <= nxt_rf0;
            rf1_cnt_ff <= nxt_rf1;
            // refresh pulses when the period wraps; software waits for start-up
            bank0_refresh_pulse <= drpw_ff[`MIC_DR_RF0] && nxt_rf0 == 13'h0000; // RULE17
            bank1_refresh_pulse <= drpw_ff[`MIC_DR_RF1] && nxt_rf1 == 13'h0000; // RULE17
        end
    end

    // access steering, registered so data outputs come from flops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_addr <= 32'h00000000;
            access_time <= 4'h0;
            cpu_stall <= 1'b0;
            bank_mode <= 2'b00;
            bank_edo <= 1'b0;
            ras_cas_delay <= 2'b00;
            card_wait <= 1'b0;
            card_io_strobes <= 1'b0;
            card_byte_port <= 1'b0;
            core_bus_req <= 1'b0;
            core_snoop <= 1'b0;
            dma_grant <= 1'b0;
            mem_self_refresh <= 1'b1;
            mem_signals_low <= 1'b1;
        end else begin
            if (hit(cpu_addr[31:9], rm1s_ff, rm1m_ff)) // RULE23
                mem_addr <= {rm1d_ff, cpu_addr[8:0]};
            else if (hit(cpu_addr[31:9], rm2s_ff, rm2m_ff)) // RULE23
                mem_addr <= {rm2d_ff, cpu_addr[8:0]};
            else
                mem_addr <= cpu_addr;
            // second time used only for page-mode read beats
            if (!cpu_write && cpu_burst_beat &&
                card_ff[`MIC_CARD_PAGE_LO + {cpu_sel_mem, cpu_sel[1:0]}]) // RULE1
                access_time <= 4'h2; // RULE25
            else
                access_time <= 4'h1; // RULE25
            bank_mode <= mem_bank ? bank1_width_config : bank0_width_config; // RULE26
            bank_edo <= mem_bank ? drpw_ff[`MIC_DR_EDO1] : drpw_ff[`MIC_DR_EDO0]; // RULE6
            ras_cas_delay <= 2'b01 + {1'b0, mem_bank ? drpw_ff[`MIC_DR_RC1] :
                drpw_ff[`MIC_DR_RC0]}; // RULE13
            card_wait <= card_slot2 ? (card_ff[`MIC_CARD_WAIT2] & ~w2_ff[1]) :
                (card_ff[`MIC_CARD_WAIT1] & ~w1_ff[1]); // RULE3
            card_io_strobes <= card_io_space & (card_slot2 ? card_ff[`MIC_CARD_IO2] :
                card_ff[`MIC_CARD_IO1]); // RULE4
            card_byte_port <= card_ff[`MIC_CARD_BYTE]; // RULE5
            core_bus_req <= dma_start & ~ext_arb; // RULE7
            dma_grant <= ext_arb ? (dma_start & ~(cpu_req & cpu_cache_miss)) : // RULE8
                (dma_start & ack_ff[1]); // RULE7
            cpu_stall <= ext_arb & dma_start & cpu_req & cpu_cache_miss; // RULE9
            core_snoop <= dma_start & dma_write & ~drpw_ff[`MIC_DR_NOSNOOP]; // RULE10
            mem_self_refresh <= drpw_ff[`MIC_DR_SLEEP]; // RULE15
            mem_signals_low <= drpw_ff[`MIC_DR_SLEEP]; // RULE15
        end
    end
endmodule // mic_top

//--- shared/mic_defines.vh
// Purpose: offsets, field positions, reset values and timing counts for mic_top
// Assumes: 32-bit apb, byte addresses
// Notes: definitions only
`ifndef MIC_DEFINES_VH
`define MIC_DEFINES_VH
// register byte offsets
`define MIC_OFF_CARD 12'h00c
`define MIC_OFF_DRPW 12'h010
`define MIC_OFF_RM2S 12'h014
`define MIC_OFF_RM1S 12'h018
`define MIC_OFF_RM2D 12'h01c
`define MIC_OFF_RM1D 12'h020
`define MIC_OFF_STAT 12'h024
// card timing / page mode fields
`define MIC_CARD_PAGE_HI 15
`define MIC_CARD_PAGE_LO 8
`define MIC_CARD_WAIT2 7
`define MIC_CARD_WAIT1 6
`define MIC_CARD_IO2 5
`define MIC_CARD_IO1 4
`define MIC_CARD_BYTE 3
`define MIC_CARD_RESET 32'h00000000
`define MIC_CARD_WMASK 32'hfffffff8
// refresh / power / watchdog fields
`define MIC_DR_EDO1 31
`define MIC_DR_EDO0 30
`define MIC_DR_ARB 29
`define MIC_DR_NOSNOOP 28
`define MIC_DR_IRQCLR 27
`define MIC_DR_RC1 26
`define MIC_DR_RC0 25
`define MIC_DR_WDEN 24
`define MIC_DR_WDLEN_HI 23
`define MIC_DR_WDLEN_LO 20
`define MIC_DR_SLEEP 16
`define MIC_DR_RF1 15
`define MIC_DR_RF0 14
`define MIC_DR_RP1_HI 13
`define MIC_DR_RP1_LO 8
`define MIC_DR_RP0_HI 5
`define MIC_DR_RP0_LO 0
`define MIC_DR_RESET 32'h00010000
`define MIC_DR_WMASK 32'hfff1ff3f
// remap fields
`define MIC_RM_ADDR_LO 9
`define MIC_RM_MASK_HI 3
// watchdog: timeout = (length+1) * step cycles
`define MIC_WD_STEP 8'h10
// refresh period: (period+1) * step + 1 cycles
`define MIC_RF_STEP 8'h40
`endif

//--- tb/mic_checker.sv
// Purpose: timing relations at the ports of mic_top
// Assumes: one clock domain, presetn async active low
// Notes: keeps a shadow of the control word written over apb
`include "mic_defines.vh"
module mic_checker (
    // apb side
    input wire pclk, input wire presetn, input wire psel, input wire penable,
    input wire pwrite, input wire [11:0] paddr, input wire [31:0] pwdata,
    // core, dma and memory side
    input wire cpu_req, input wire cpu_reg_space, input wire mem_write_busy,
    input wire core_bus_req, input wire core_snoop, input wire dma_grant,
    input wire write_timeout_irq, input wire mem_self_refresh, input wire mem_signals_low,
    input wire bank0_refresh_pulse
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire drpw_wr = psel && penable && pwrite && (paddr == `MIC_OFF_DRPW);
    wire clr_wr = drpw_wr && pwdata[27];
    wire wake = (cpu_req && !cpu_reg_space) || drpw_wr;
    reg [31:0] drpw_ff;
    reg [9:0] busy_ff;
    wire arb_on = drpw_ff[29] && drpw_ff[28];
    // shadow lags nothing: it updates at the same edge as the design register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drpw_ff <= 32'h0;
            busy_ff <= 10'h0;
        end else begin
            if (drpw_wr) drpw_ff <= pwdata & `MIC_DR_WMASK;
            busy_ff <= (mem_write_busy && drpw_ff[24]) ? busy_ff + 10'h1 : 10'h0;
        end
    end
    chk_sleep_pins: assert property (mem_self_refresh == mem_signals_low)
        else $error("self refresh and low drive disagree");
    chk_wake_access: assert property (cpu_req && !cpu_reg_space && !drpw_wr |-> ##[1:3]
        !mem_self_refresh) else $error("memory access left power-down on");
    chk_stay_asleep: assert property (mem_self_refresh && !wake && !$past(wake)
        |=> mem_self_refresh) else $error("power-down ended without cause");
    chk_irq_hold: assert property ($fell(write_timeout_irq) |-> $past(clr_wr)
        || $past(clr_wr, 2) || $past(clr_wr, 3)) else $error("irq dropped without clear");
    chk_irq_cause: assert property ($rose(write_timeout_irq) |->
        busy_ff >= (drpw_ff[23:20] + 1) * 16) else $error("irq before write timed out");
    chk_arb_noreq: assert property (arb_on && $past(arb_on, 4) |-> !core_bus_req)
        else $error("bus request under own arbitration");
    chk_snoop_off: assert property (drpw_ff[28] && $past(drpw_ff[28], 4) |-> !core_snoop)
        else $error("snoop while disabled");
    chk_grant_req: assert property ($rose(dma_grant) && !arb_on |-> $past(core_bus_req))
        else $error("dma grant without bus request");
    chk_refresh_gate: assert property (bank0_refresh_pulse |-> drpw_ff[14])
        else $error("refresh pulse while disabled");
    cover property ($rose(write_timeout_irq));
    cover property ($rose(dma_grant));
    cover property ($fell(mem_self_refresh));
endmodule // mic_checker
bind mic_top mic_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .cpu_req, .cpu_reg_space, .mem_write_busy, .core_bus_req, .core_snoop, .dma_grant,
    .write_timeout_irq, .mem_self_refresh, .mem_signals_low, .bank0_refresh_pulse);

//--- tb/mic_partner.sv
// Purpose: processor core answering bus requests for dma
// Assumes: lat sets how many cycles the core needs before it acknowledges
// Notes: acknowledge drops as soon as the request is withdrawn
module mic_partner (
    // arbitration handshake
    input wire pclk,
    input wire presetn,
    input wire core_bus_req,
    input wire [3:0] lat,
    output logic core_bus_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_ff;
    // the core ends its current cycle first, so a slow answer is the normal case
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 4'h0;
            core_bus_ack <= 1'b0;
        end else begin
            cnt_ff <= !core_bus_req ? 4'h0 : (cnt_ff == 4'hf) ? cnt_ff : cnt_ff + 4'h1;
            core_bus_ack <= core_bus_req && (cnt_ff >= lat);
        end
    end
endmodule // mic_partner

//--- tb/mic_top_tb_top.sv
// Purpose: self-checking bench for mic_top
// Assumes: pclk 100 ns, zero-wait apb slave
// Notes: outputs are read at the edge, before that edge's updates land
`include "mic_defines.vh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin n_fail++; $display("BAD %s exp %0h got %0h", n, e, s); end end
module mic_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, cpu_req = '0;
    logic cpu_write = '0, cpu_reg_space = '0, cpu_cache_miss = '0, cpu_sel_mem = '0;
    logic cpu_burst_beat = '0, mem_bank = '0, card_slot2 = '0, card_io_space = '0;
    logic slot1_wait_n = '1, slot2_wait_n = '1, dma_start = '0, dma_write = '0;
    logic mem_write_busy = '0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, cpu_addr = '0, lfsr = 32'h5999;
    logic [2:0] cpu_sel = '0;
    logic [1:0] bank0_width_config = '0, bank1_width_config = '0;
    logic [3:0] ack_lat = '0;
    wire [31:0] prdata, mem_addr;
    wire [3:0] access_time;
    wire [1:0] bank_mode, ras_cas_delay;
    wire pready, pslverr, cpu_stall, bank_edo, card_wait, card_io_strobes, card_byte_port;
    wire core_bus_ack, core_bus_req, core_snoop, dma_grant, write_timeout_irq;
    wire mem_self_refresh, mem_signals_low, bank0_refresh_pulse, bank1_refresh_pulse;
    logic [31:0] mdl[int];
    int n_fail = 0, checks = 0;
    mic_top uut (.*);
    mic_partner u_core (.pclk(pclk), .presetn(presetn), .core_bus_req(core_bus_req),
        .lat(ack_lat), .core_bus_ack(core_bus_ack));
    always #50 pclk = ~pclk;
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    // one apb transfer; an idle cycle follows so strobes never change twice in a step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
        if (a == `MIC_OFF_CARD) mdl[a] = d & `MIC_CARD_WMASK;
        if (a == `MIC_OFF_DRPW) mdl[a] = d & `MIC_DR_WMASK;
    endtask
    task automatic rd(input logic [11:0] a);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        `CHK("rdata", mdl[a], r);
    endtask
    task automatic gap(input int b, output int n);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (!(b ? bank1_refresh_pulse : bank0_refresh_pulse) && n < 400);
    endtask
    task end_sim();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #3000000;
        n_fail++;
        end_sim();
    end
    initial begin
        logic [31:0] d, r, w;
        int i, t;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        mdl[`MIC_OFF_CARD] = `MIC_CARD_RESET;
        mdl[`MIC_OFF_DRPW] = `MIC_DR_RESET;
        mdl[12'h0f0] = 32'h0;
        foreach (mdl[a]) rd(a[11:0]);
        `CHK("sleep", 1'b1, mem_self_refresh);
        // register-space traffic must not wake the memories, any other access must
        {cpu_req, cpu_reg_space} <= 2'b11;
        repeat (5) @(posedge pclk);
        `CHK("sleep", 1'b1, mem_self_refresh);
        cpu_reg_space <= 1'b0;
        repeat (5) @(posedge pclk);
        `CHK("wake", 1'b0, mem_self_refresh);
        mdl[`MIC_OFF_DRPW][16] = 1'b0;
        rd(`MIC_OFF_DRPW);
        for (i = 0; i < 8; i++) begin
            d = rnd();
            wr(`MIC_OFF_CARD, d);
            wr(`MIC_OFF_DRPW, d & 32'hc6000000);
            r = rnd();
            {cpu_sel_mem, cpu_write, cpu_burst_beat, card_slot2, card_io_space} <= r[4:0];
            {slot1_wait_n, slot2_wait_n, mem_bank, cpu_cache_miss} <= r[8:5];
            cpu_sel <= {1'b0, r[10:9]};
            {bank1_width_config, bank0_width_config} <= r[14:11];
            repeat (6) @(posedge pclk);
            rd(`MIC_OFF_CARD);
            `CHK("iostb", d[4 + r[1]] & r[0], card_io_strobes);
            `CHK("wait", d[6 + r[1]] & ~(r[1] ? r[7] : r[8]), card_wait);
            `CHK("byte", d[3], card_byte_port);
            t = (d[(r[4] ? 12 : 8) + r[10:9]] & ~r[3] & r[2]) ? 2 : 1;
            `CHK("atime", t, access_time);
            `CHK("bmode", r[6] ? r[14:13] : r[12:11], bank_mode);
            `CHK("edo", d[30 + r[6]], bank_edo);
            `CHK("rcd", d[25 + r[6]] ? 2 : 1, ras_cas_delay);
        end
        for (i = 0; i < 2; i++) begin
            d = rnd() & 32'hfffffe00;
            w = rnd() & 32'hfffffe00;
            wr(12'h018 - 4 * i, d);
            wr(12'h020 - 4 * i, w);
            r = rnd() & 32'h1ff;
            cpu_addr <= d | r;
            repeat (4) @(posedge pclk);
            `CHK("remap", w | r, mem_addr);
            cpu_addr <= ~d;
            repeat (4) @(posedge pclk);
            `CHK("pass", ~d, mem_addr);
        end
        cpu_cache_miss <= 1'b0;
        for (i = 0; i < 3; i++) begin
            wr(`MIC_OFF_DRPW, (i == 2) ? 32'h30000000 : 32'h0);
            ack_lat <= (i == 1) ? 4'h7 : 4'h0;
            // the dma request stands until it is granted
            {dma_write, dma_start} <= 2'b11;
            for (t = 0; t < 100 && dma_grant !== 1'b1; t++) @(posedge pclk);
            `CHK("grant", 1'b1, dma_grant);
            `CHK("busreq", i < 2, core_bus_req);
            `CHK("snoop", i < 2, core_snoop);
            if (i == 2) begin
                cpu_cache_miss <= 1'b1;
                repeat (2) @(posedge pclk);
                `CHK("stall", 1'b1, cpu_stall);
                `CHK("nogrant", 1'b0, dma_grant);
                cpu_cache_miss <= 1'b0;
            end
            dma_start <= 1'b0;
            repeat (20) @(posedge pclk);
        end
        wr(`MIC_OFF_DRPW, 32'h01100000);
        mem_write_busy <= 1'b1;
        for (t = 0; t < 200 && write_timeout_irq !== 1'b1; t++) @(posedge pclk);
        `CHK("wdtime", 1'b1, t >= 2 * `MIC_WD_STEP && t <= 2 * `MIC_WD_STEP + 8);
        mem_write_busy <= 1'b0;
        repeat (10) @(posedge pclk);
        `CHK("irq", 1'b1, write_timeout_irq);
        wr(`MIC_OFF_DRPW, 32'h08000000);
        wr(`MIC_OFF_DRPW, 32'h0);
        repeat (4) @(posedge pclk);
        `CHK("irqclr", 1'b0, write_timeout_irq);
        for (i = 0; i < 2; i++) begin
            wr(`MIC_OFF_DRPW, i ? 32'h0000c100 : 32'h00004000);
            gap(i, t);
            gap(i, t);
            `CHK("rfper", (i + 1) * `MIC_RF_STEP + 1, t);
        end
        {cpu_req, cpu_reg_space} <= 2'b00;
        wr(`MIC_OFF_DRPW, 32'h0001c100);
        repeat (4) @(posedge pclk);
        `CHK("sleep", 1'b1, mem_self_refresh);
        end_sim();
    end
endmodule // mic_top_tb_top
